// ---- verilog/secp_top.sv ----
// Serial EEPROM configuration port: automatic load and software bit-bang
//
// Behaviour
// - During the automatic load the serial clock is the core clock divided by 256.
// - Every reset release with the chip select pin pulled high starts an automatic read of the EEPROM.
// - Software may toggle the serial clock line through the port control bits.
// - Chip select is driven high to select the memory and low to deselect it.
// - The automatic read runs only if the chip select pin reads high from its pull-up.
// - Software may assert and release chip select through the port control bits.
// - Write data goes out on its own pin, settable by software.
// - Read data is sampled on its own pin and its level is readable by software.
`timescale 1ns/100ps
module secp_top
  import secp_pkg::*;
#(
  parameter int LOAD_BITS = LOAD_BITS_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ctl_serial_clock,
  input wire logic ctl_chip_select,
  input wire logic ctl_write_data,
  output logic sts_read_data,
  output logic sts_loading,
  output logic eeprom_serial_clock,
  input wire logic eeprom_chip_select_in,
  output logic eeprom_chip_select_out,
  output logic eeprom_chip_select_oe_n,
  output logic eeprom_write_data,
  input wire logic eeprom_read_data,
  output logic [FIFO_W-1:0] cfg_data,
  output logic cfg_valid,
  input wire logic cfg_ready
);
  // ----------------------------------------
  // Reset and pin synchronisers
  // ----------------------------------------
  logic rst_s1;
  logic rst_n;
  logic rd_s1;
  logic rd_s2;
  logic cs_s1;
  logic cs_s2;
  logic [1:0] settle;

  // Reset release through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Pin synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_s1 <= 1'b0;
      rd_s2 <= 1'b0;
      cs_s1 <= 1'b0;
      cs_s2 <= 1'b0;
    end else begin
      rd_s1 <= eeprom_read_data;
      rd_s2 <= rd_s1;
      cs_s1 <= eeprom_chip_select_in;
      cs_s2 <= cs_s1;
    end
  end

  // Strap settle: both pin stages filled before the select level is trusted
  // Without it the loader would see the reset value of the stages and skip the read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle <= 2'h0;
    end else begin
      settle <= {settle[0], 1'b1};
    end
  end

  // ----------------------------------------
  // Automatic loader
  // ----------------------------------------
  secp_state_e state;
  logic [7:0] div_cnt;
  logic sck;
  logic [31:0] bit_cnt;
  logic [FIFO_W-1:0] shift;
  logic [2:0] bit_idx;
  logic push;
  logic fifo_ready;
  logic rise;
  logic fall;
  logic stall;

  assign rise = (div_cnt == SCK_HALF_LAST) && !sck && !stall;
  assign fall = (div_cnt == SCK_HALF_LAST) && sck;
  // Hold the clock low while a full byte waits on the FIFO
  assign stall = push && !fifo_ready;

  // Load sequencer; chip select strap checked after reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SECP_IDLE;
    end else begin
      case (state)
        SECP_IDLE: begin
          if (settle[1]) begin
            if (cs_s2) begin
              state <= SECP_LOAD;
            end else begin
              state <= SECP_DONE;
            end
          end
        end
        SECP_LOAD: begin
          if (fall && bit_cnt == 32'(LOAD_BITS - 1)) begin
            state <= SECP_DONE;
          end
        end
        default: begin
          state <= SECP_DONE;
        end
      endcase
    end
  end

  // Divide by 256: half-period counter and clock level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 8'h00;
      sck <= 1'b0;
    end else if (state != SECP_LOAD) begin
      div_cnt <= 8'h00;
      sck <= 1'b0;
    end else if (rise || fall) begin
      div_cnt <= 8'h00;
      sck <= !sck;
    end else if (div_cnt != SCK_HALF_LAST) begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // Sample read data on the rising serial clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift <= '0;
      bit_idx <= 3'h0;
      push <= 1'b0;
    end else begin
      if (push && fifo_ready) begin
        push <= 1'b0;
      end
      if (state == SECP_LOAD && rise) begin
        shift <= {shift[FIFO_W-2:0], rd_s2};
        bit_idx <= bit_idx + 3'h1;
        if (bit_idx == BIT_LAST) begin
          push <= 1'b1;
        end
      end
    end
  end

  // Count bits loaded
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 32'h0000_0000;
    end else if (state == SECP_LOAD && fall) begin
      bit_cnt <= bit_cnt + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // Configuration data buffer
  // ----------------------------------------
  secp_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) secp_fifo_i (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(shift),
    .in_valid(push),
    .in_ready(fifo_ready),
    .out_data(cfg_data),
    .out_valid(cfg_valid),
    .out_ready(cfg_ready)
  );

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Registered line drivers, automatic until load ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eeprom_serial_clock <= 1'b0;
      eeprom_chip_select_out <= 1'b0;
      eeprom_chip_select_oe_n <= 1'b1;
      eeprom_write_data <= 1'b0;
      sts_read_data <= 1'b0;
      sts_loading <= 1'b1;
    end else begin
      sts_read_data <= rd_s2;
      sts_loading <= (state != SECP_DONE);
      if (state == SECP_DONE) begin
        eeprom_serial_clock <= ctl_serial_clock;
        eeprom_chip_select_out <= ctl_chip_select;
        eeprom_chip_select_oe_n <= 1'b0;
        eeprom_write_data <= ctl_write_data;
      end else if (state == SECP_LOAD) begin
        eeprom_serial_clock <= sck;
        eeprom_chip_select_out <= 1'b1;
        eeprom_chip_select_oe_n <= 1'b0;
        eeprom_write_data <= 1'b0;
      end else begin
        eeprom_chip_select_oe_n <= 1'b1;
      end
    end
  end
endmodule

// ---- verilog/secp_pkg.sv ----
// Package of constants for the serial EEPROM configuration port
package secp_pkg;
  // Core clock and serial clock timing
  localparam int CLK_HZ = 20_000_000;
  localparam int SCK_DIV = 256;
  localparam int SCK_HALF = SCK_DIV / 2;
  localparam logic [7:0] SCK_HALF_LAST = 8'(SCK_HALF - 1);
  // Default number of bits read during the automatic load
  localparam int LOAD_BITS_DEF = 1024;
  // Fifo shape
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Automatic loader states
  typedef enum logic [1:0] {SECP_IDLE, SECP_LOAD, SECP_DONE} secp_state_e;
endpackage

// ---- verilog/secp_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
module secp_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;

  // Full and empty from pointer wrap bit
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  // Storage write
  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Write pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
    end else if (in_valid && !full) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // Read pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// ---- sim/secp_top_properties.sv ----
// Pin timing checks for the EEPROM configuration port
`timescale 1ns/100ps
module secp_top_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ctl_serial_clock,
  input wire logic ctl_chip_select,
  input wire logic ctl_write_data,
  input wire logic sts_read_data,
  input wire logic sts_loading,
  input wire logic eeprom_serial_clock,
  input wire logic eeprom_chip_select_out,
  input wire logic eeprom_chip_select_oe_n,
  input wire logic eeprom_write_data,
  input wire logic eeprom_read_data
);
  logic [15:0] hi_cnt;
  // Cycles the serial clock has stood high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) hi_cnt <= 16'h0;
    else hi_cnt <= eeprom_serial_clock ? hi_cnt + 16'h1 : 16'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_sck_high_time: assert property ($fell(eeprom_serial_clock) && $past(sts_loading)
    |-> hi_cnt == 16'h80) else $error("clock high phase");
  a_cs_in_load: assert property (sts_loading && $rose(eeprom_serial_clock)
    |-> eeprom_chip_select_out && !eeprom_chip_select_oe_n) else $error("select in load");
  a_wd_quiet: assert property (sts_loading |-> !eeprom_write_data)
    else $error("write data in load");
  a_sw_clock: assert property (!sts_loading && !$past(sts_loading, 2)
    |-> eeprom_serial_clock == $past(ctl_serial_clock)) else $error("clock copy");
  a_sw_select: assert property (!sts_loading && !$past(sts_loading, 2)
    |-> eeprom_chip_select_out == $past(ctl_chip_select)) else $error("select copy");
  a_sw_drive: assert property (!sts_loading |=> !eeprom_chip_select_oe_n)
    else $error("select released");
  a_sw_wdata: assert property (!sts_loading && !$past(sts_loading, 2)
    |-> eeprom_write_data == $past(ctl_write_data)) else $error("write copy");
  a_rd_level: assert property (!sts_loading && !$past(sts_loading, 3)
    |-> sts_read_data == $past(eeprom_read_data, 3)) else $error("read level");
endmodule
bind secp_top secp_top_properties secp_top_properties_i (.*);

// ---- sim/secp_eeprom_model.sv ----
// Serial EEPROM model streaming a fixed byte pattern
`timescale 1ns/100ps
module secp_eeprom_model (
  input wire logic sck,
  input wire logic cs,
  output logic dout
);
  int unsigned pos = 0;
  int unsigned base = 0;
  int unsigned idx;
  logic [7:0] cur;
  // Next bit after each falling clock, stream restarts on select
  always @(negedge sck) if (cs) pos <= pos + 1;
  always @(posedge cs) base <= pos;
  assign idx = pos - base;
  assign cur = 8'(idx / 8 * 37 + 5);
  // Deselected line shows the inverted bit, never a held value
  assign dout = cs ? cur[7 - idx % 8] : !cur[7 - idx % 8];
endmodule

// ---- sim/secp_top_bench.sv ----
// Self-checking bench for the EEPROM configuration port
`timescale 1ns/100ps
module secp_top_bench;
  import secp_pkg::*;
  localparam int NB = 18;
  logic clk = 0, nrst = 0, strap = 1, cfg_ready = 0;
  logic ctl_serial_clock = 0, ctl_chip_select = 0, ctl_write_data = 0;
  logic sts_read_data, sts_loading, eeprom_serial_clock, eeprom_chip_select_out;
  logic eeprom_chip_select_oe_n, eeprom_write_data, eeprom_read_data, cfg_valid;
  logic eeprom_chip_select_in;
  logic [7:0] cfg_data;
  int error_cnt = 0, n_tests = 0, hits;
  // Board pull-up or pull-down meets the select driver
  assign eeprom_chip_select_in = eeprom_chip_select_oe_n ? strap : eeprom_chip_select_out;
  always #25 clk = ~clk;
  secp_top #(.LOAD_BITS(NB * 8)) secp_top_i (.*);
  secp_eeprom_model secp_eeprom_model_i (.sck(eeprom_serial_clock),
    .cs(eeprom_chip_select_in), .dout(eeprom_read_data));
  function automatic logic [7:0] exp_byte(int n);
    return 8'(n * 37 + 5);
  endfunction
  task automatic chk(logic got, logic exp, string m);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic chk8(logic [7:0] got, logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t byte %h", $time, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic restart(logic s);
    @(posedge clk);
    nrst <= 1'b0;
    strap <= s;
    ctl_serial_clock <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    hits = 0;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    final_report;
  end
  initial begin
    void'($urandom(54475));
    restart(1'b1);
    // Full FIFO stalls the load, then bytes drain in order
    repeat (17 * 2048 + 256) @(negedge clk);
    repeat (300) begin @(negedge clk); hits += eeprom_serial_clock; end
    chk(hits == 0 && sts_loading, 1'b1, "no stall");
    for (int i = 0; i < NB; i++) begin
      hits = 0;
      do begin @(negedge clk); hits++; end while (!cfg_valid && hits < 3000);
      chk8(cfg_data, exp_byte(i));
      repeat ($urandom % 3) @(posedge clk);
      @(posedge clk) cfg_ready <= 1'b1;
      @(posedge clk) cfg_ready <= 1'b0;
    end
    repeat (SCK_DIV) @(negedge clk);
    chk(sts_loading, 1'b0, "load not ended");
    $display("load test done");
    // Software sets the pins once loading is over
    repeat (8) begin
      @(posedge clk) {ctl_serial_clock, ctl_chip_select, ctl_write_data} <= 3'($urandom);
      repeat (6) @(negedge clk);
      chk(eeprom_serial_clock, ctl_serial_clock, "clock");
      chk(eeprom_chip_select_out, ctl_chip_select, "select");
      chk(eeprom_chip_select_oe_n, 1'b0, "select drive");
      chk(eeprom_write_data, ctl_write_data, "write");
      chk(sts_read_data, eeprom_read_data, "read");
    end
    $display("software test done");
    // No pull-up means no automatic read
    restart(1'b0);
    repeat (20) begin @(negedge clk); hits += eeprom_serial_clock; end
    chk(hits == 0 && !sts_loading && !cfg_valid, 1'b1, "read not skipped");
    $display("strap test done");
    // Each reset with the pull-up starts a new read
    restart(1'b1);
    repeat (140) begin @(negedge clk); hits += eeprom_serial_clock; end
    chk(sts_loading && eeprom_chip_select_out, 1'b1, "no load");
    chk(hits > 0, 1'b1, "clock idle");
    $display("reload test done");
    final_report;
  end
endmodule
